// File: logic/irvm_pkg.sv
// Package with map, field layout and carrier types of the interrupt request and vector map
package irvm_pkg;

  // ****************************************
  // Vector numbers (word address equals number)
  // ****************************************
  localparam int unsigned NUM_VECTORS = 13;
  localparam logic [3:0] VEC_RESET = 4'h0;
  localparam logic [3:0] VEC_MEM_SCAN_NMI = 4'h1;
  localparam logic [3:0] VEC_SUPPLY_LEVEL = 4'h2;
  localparam logic [3:0] VEC_PORT_A = 4'h3;
  localparam logic [3:0] VEC_PORT_B = 4'h4;
  localparam logic [3:0] VEC_PORT_C = 4'h5;
  localparam logic [3:0] VEC_RTC_COUNT = 4'h6;
  localparam logic [3:0] VEC_RTC_TICK = 4'h7;
  localparam logic [3:0] VEC_TIMER_OVF = 4'h8;
  localparam logic [3:0] VEC_TIMER_HUNF = 4'h9;
  localparam logic [3:0] VEC_TIMER_CMP0 = 4'ha;
  localparam logic [3:0] VEC_TIMER_CMP1 = 4'hb;
  localparam logic [3:0] VEC_TIMER_CMP2 = 4'hc;

  // ****************************************
  // Variant pin counts
  // ****************************************
  localparam int unsigned PORT_B_MIN_PINS = 14;
  localparam int unsigned PORT_C_MIN_PINS = 20;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [3:0] OFS_FLAGS = 4'h0;
  localparam logic [3:0] OFS_ENABLE = 4'h4;
  localparam logic [3:0] OFS_CONTROL = 4'h8;
  localparam logic [3:0] OFS_STATUS = 4'hc;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int unsigned CTRL_GLOBAL_BIT = 0;
  localparam int unsigned CTRL_SPLIT_BIT = 1;
  localparam int unsigned STAT_VALID_BIT = 16;
  localparam int unsigned STAT_NUMBER_LSB = 20;
  localparam logic RESET_GLOBAL_ENABLE = 1'b0;
  localparam logic RESET_SPLIT_MODE = 1'b0;
  localparam logic RESET_FLAG = 1'b0;
  localparam logic RESET_ENABLE = 1'b0;
  localparam logic [31:0] RESET_READDATA = 32'h0000_0000;

  // ****************************************
  // Carrier types
  // ****************************************
  typedef struct packed {
    logic valid;
    logic [3:0] number;
    logic [7:0] word_address;
  } irvm_vector_type;

  typedef struct packed {
    logic [3:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } irvm_bus_type;

endpackage : irvm_pkg

// File: logic/irvm_source_cell.sv
// One interrupt source: sticky flag and software enable bit
`timescale 1ns/1ps
module irvm_source_cell (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic event_in,
  input wire logic clear_strobe,
  input wire logic enable_write,
  input wire logic enable_value,
  output logic flag,
  output logic enable
);

  typedef struct packed {
    logic flag;
    logic enable;
  } irvm_cell_state_type;

  irvm_cell_state_type state;
  irvm_cell_state_type next_state;

  always_comb begin
    next_state = state;
    // Set wins over a clear in the same cycle
    next_state.flag = event_in | (state.flag & ~clear_strobe);
    if (enable_write) begin
      next_state.enable = enable_value;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state <= '{flag: irvm_pkg::RESET_FLAG, enable: irvm_pkg::RESET_ENABLE};
    end else begin
      state <= next_state;
    end
  end

  assign flag = state.flag;
  assign enable = state.enable;

  flag_sets_a: assert property (@(posedge clock) disable iff (!reset_n) event_in |=> flag)
    else $error("flag did not set after event");

  flag_holds_a: assert property (@(posedge clock) disable iff (!reset_n)
      flag && !clear_strobe |=> flag)
    else $error("flag dropped without a clear");

  enable_sw_only_a: assert property (@(posedge clock) disable iff (!reset_n)
      !enable_write |=> $stable(enable))
    else $error("enable changed without a write");

endmodule : irvm_source_cell

// File: logic/irvm_vector_encoder.sv
// Registered priority encoder: lowest pending vector number wins
`timescale 1ns/1ps
module irvm_vector_encoder (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [irvm_pkg::NUM_VECTORS-1:0] request,
  output irvm_pkg::irvm_vector_type vector
);

  irvm_pkg::irvm_vector_type state;
  irvm_pkg::irvm_vector_type next_state;

  always_comb begin
    next_state = '0;
    for (int i = irvm_pkg::NUM_VECTORS - 1; i >= 1; i--) begin
      if (request[i]) begin
        next_state.valid = 1'b1;
        next_state.number = 4'(i);
        // Program word address equals vector number
        next_state.word_address = 8'(i);
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign vector = state;

  vector_address_a: assert property (@(posedge clock) disable iff (!reset_n)
      vector.valid |-> vector.word_address == {4'h0, vector.number} && vector.number != 4'h0)
    else $error("vector word address differs from vector number");

endmodule : irvm_vector_encoder

// File: logic/irvm_top.sv
// Interrupt request generation and vector map with Avalon-MM register slave
//
// Added by the designer: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps

// Summary of operation
// - A source event sets its sticky flag in the flags register.
// - Source enable bits change only through software writes to the enable register.
// - A request is raised exactly when flag and source enable are one and, for maskable vectors, global enable is set.
// - The request is a level that stays until its flag or source enable is cleared, or global enable for maskable vectors.
// - Maskable requests reach the CPU only while global enable is set.
// - Every vector from 1 to 12 belongs to one peripheral; its sources share the vector.
// - Vector 1 is the memory-scan non-maskable request, ignoring global enable.
// - Vector 2 carries the supply level monitor request.
// - Port A uses vector 3; ports B and C exist only with enough pins.
// - Vector 6 carries counter events, vector 7 the periodic tick.
// - Vector 8 is timer overflow, or low-byte underflow in split mode.
// - Vector 9 is unused in normal mode, high-byte underflow in split.
// - Vector 10 is compare 0, or low-byte compare 0 in split mode.
// - Vectors 11 and 12 are compares 1 and 2, or low-byte equivalents.
module irvm_top #(
  parameter int unsigned PIN_COUNT = 20
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic memory_scan_nonmaskable_irq,
  input wire logic supply_level_monitor_irq,
  input wire logic port_a_pin_irq,
  input wire logic port_b_pin_irq,
  input wire logic port_c_pin_irq,
  input wire logic realtime_counter_irq,
  input wire logic periodic_tick_irq,
  input wire logic timer_a_overflow_irq,
  input wire logic timer_a_low_underflow_irq,
  input wire logic timer_a_high_underflow_irq,
  input wire logic timer_a_compare0_irq,
  input wire logic timer_a_low_compare0_irq,
  input wire logic timer_a_compare1_irq,
  input wire logic timer_a_low_compare1_irq,
  input wire logic timer_a_compare2_irq,
  input wire logic timer_a_low_compare2_irq,
  output logic [irvm_pkg::NUM_VECTORS-1:0] irq_request,
  output logic nonmaskable_request,
  output irvm_pkg::irvm_vector_type pending_vector,
  output logic global_enable,
  output logic split_mode
);

  localparam int unsigned NV = irvm_pkg::NUM_VECTORS;

  // ****************************************
  // Decoding helpers
  // ****************************************

  // Vector exists on this variant
  function automatic logic vector_present(input int unsigned v, input int unsigned pins);
    logic present;
    present = (v != 32'(irvm_pkg::VEC_RESET));
    if (v == 32'(irvm_pkg::VEC_PORT_B)) begin
      present = (pins >= irvm_pkg::PORT_B_MIN_PINS);
    end
    if (v == 32'(irvm_pkg::VEC_PORT_C)) begin
      present = (pins >= irvm_pkg::PORT_C_MIN_PINS);
    end
    return present;
  endfunction : vector_present

  // Register select for a bus address
  function automatic logic reg_hit(input logic [3:0] address, input logic [3:0] offset);
    return address == offset;
  endfunction : reg_hit

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic ack;
    logic [31:0] readdata;
    logic global_enable;
    logic split_mode;
  } irvm_top_state_type;

  irvm_top_state_type state;
  irvm_top_state_type next_state;

  irvm_pkg::irvm_bus_type bus;
  logic [NV-1:0] event_vec;
  logic [NV-1:0] flag;
  logic [NV-1:0] enable;
  logic [NV-1:0] clear_strobe;
  logic [NV-1:0] present;
  logic [NV-1:0] active;
  logic [NV-1:0] request_all;
  logic write_take;
  logic enable_write;
  logic flags_write;

  assign bus = '{address: avs_address, read: avs_read, write: avs_write, writedata: avs_writedata};

  // ****************************************
  // Source routing to vectors
  // ****************************************

  // Each vector is fed by one peripheral; mode selects which of its sources
  always_comb begin
    event_vec = '0;
    event_vec[irvm_pkg::VEC_MEM_SCAN_NMI] = memory_scan_nonmaskable_irq;
    event_vec[irvm_pkg::VEC_SUPPLY_LEVEL] = supply_level_monitor_irq;
    event_vec[irvm_pkg::VEC_PORT_A] = port_a_pin_irq;
    event_vec[irvm_pkg::VEC_PORT_B] = port_b_pin_irq;
    event_vec[irvm_pkg::VEC_PORT_C] = port_c_pin_irq;
    event_vec[irvm_pkg::VEC_RTC_COUNT] = realtime_counter_irq;
    event_vec[irvm_pkg::VEC_RTC_TICK] = periodic_tick_irq;
    if (state.split_mode) begin
      event_vec[irvm_pkg::VEC_TIMER_OVF] = timer_a_low_underflow_irq;
      event_vec[irvm_pkg::VEC_TIMER_HUNF] = timer_a_high_underflow_irq;
      event_vec[irvm_pkg::VEC_TIMER_CMP0] = timer_a_low_compare0_irq;
      event_vec[irvm_pkg::VEC_TIMER_CMP1] = timer_a_low_compare1_irq;
      event_vec[irvm_pkg::VEC_TIMER_CMP2] = timer_a_low_compare2_irq;
    end else begin
      event_vec[irvm_pkg::VEC_TIMER_OVF] = timer_a_overflow_irq;
      event_vec[irvm_pkg::VEC_TIMER_HUNF] = 1'b0;
      event_vec[irvm_pkg::VEC_TIMER_CMP0] = timer_a_compare0_irq;
      event_vec[irvm_pkg::VEC_TIMER_CMP1] = timer_a_compare1_irq;
      event_vec[irvm_pkg::VEC_TIMER_CMP2] = timer_a_compare2_irq;
    end
    // Absent vectors never see an event
    event_vec = event_vec & present;
  end

  // ****************************************
  // Register bus slave
  // ****************************************

  // One wait cycle: ack rises the cycle after a request is seen
  assign avs_waitrequest = (bus.read | bus.write) & ~state.ack;
  assign write_take = bus.write & state.ack;
  assign enable_write = write_take & reg_hit(bus.address, irvm_pkg::OFS_ENABLE);
  assign flags_write = write_take & reg_hit(bus.address, irvm_pkg::OFS_FLAGS);

  always_comb begin
    next_state = state;
    next_state.ack = (bus.read | bus.write) & ~state.ack;
    if (bus.read & ~state.ack) begin
      next_state.readdata = '0;
      unique case (bus.address)
        irvm_pkg::OFS_FLAGS: begin
          next_state.readdata[NV-1:0] = flag;
        end
        irvm_pkg::OFS_ENABLE: begin
          next_state.readdata[NV-1:0] = enable;
        end
        irvm_pkg::OFS_CONTROL: begin
          next_state.readdata[irvm_pkg::CTRL_GLOBAL_BIT] = state.global_enable;
          next_state.readdata[irvm_pkg::CTRL_SPLIT_BIT] = state.split_mode;
        end
        irvm_pkg::OFS_STATUS: begin
          next_state.readdata[NV-1:0] = irq_request;
          next_state.readdata[irvm_pkg::STAT_VALID_BIT] = pending_vector.valid;
          next_state.readdata[irvm_pkg::STAT_NUMBER_LSB +: 4] = pending_vector.number;
        end
        default: begin
          next_state.readdata = '0;
        end
      endcase
    end
    if (write_take & reg_hit(bus.address, irvm_pkg::OFS_CONTROL)) begin
      next_state.global_enable = bus.writedata[irvm_pkg::CTRL_GLOBAL_BIT];
      next_state.split_mode = bus.writedata[irvm_pkg::CTRL_SPLIT_BIT];
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state <= '{ack: 1'b0,
                 readdata: irvm_pkg::RESET_READDATA,
                 global_enable: irvm_pkg::RESET_GLOBAL_ENABLE,
                 split_mode: irvm_pkg::RESET_SPLIT_MODE};
    end else begin
      state <= next_state;
    end
  end

  assign avs_readdata = state.readdata;
  assign global_enable = state.global_enable;
  assign split_mode = state.split_mode;

  // ****************************************
  // Source cells
  // ****************************************
  generate
    for (genvar v = 0; v < NV; v++) begin : g_src
      assign present[v] = vector_present(v, PIN_COUNT);
      // Write one to clear
      assign clear_strobe[v] = flags_write & bus.writedata[v];
      if (v == 0) begin : g_reset_entry
        // Reset entry has no source
        assign flag[v] = 1'b0;
        assign enable[v] = 1'b0;
      end else begin : g_cell
        irvm_source_cell u_cell (
          .clock(clock),
          .reset_n(reset_n),
          .event_in(event_vec[v]),
          .clear_strobe(clear_strobe[v]),
          .enable_write(enable_write),
          .enable_value(bus.writedata[v]),
          .flag(flag[v]),
          .enable(enable[v])
        );
      end
    end
  endgenerate

  // ****************************************
  // Requests
  // ****************************************

  // Level request: flag and enable, no memory of its own
  assign active = flag & enable & present;
  assign nonmaskable_request = active[irvm_pkg::VEC_MEM_SCAN_NMI];

  always_comb begin
    irq_request = '0;
    if (state.global_enable) begin
      irq_request = active;
    end
    // Non-maskable vector bypasses the global enable
    irq_request[irvm_pkg::VEC_MEM_SCAN_NMI] = nonmaskable_request;
    irq_request[irvm_pkg::VEC_RESET] = 1'b0;
    request_all = irq_request;
  end

  irvm_vector_encoder u_encoder (
    .clock(clock),
    .reset_n(reset_n),
    .request(request_all),
    .vector(pending_vector)
  );

  // ****************************************
  // Checks
  // ****************************************
  request_exact_a: assert property (@(posedge clock) disable iff (!reset_n)
      irq_request[irvm_pkg::VEC_PORT_A] ==
      (flag[irvm_pkg::VEC_PORT_A] & enable[irvm_pkg::VEC_PORT_A] & global_enable))
    else $error("port A request differs from flag and enable");

  global_gate_a: assert property (@(posedge clock) disable iff (!reset_n)
      !global_enable |-> (irq_request >> 2) == '0)
    else $error("maskable request without global enable");

  nmi_bypass_a: assert property (@(posedge clock) disable iff (!reset_n)
      flag[irvm_pkg::VEC_MEM_SCAN_NMI] && enable[irvm_pkg::VEC_MEM_SCAN_NMI]
      |-> nonmaskable_request && irq_request[irvm_pkg::VEC_MEM_SCAN_NMI])
    else $error("non-maskable request missing");

  level_hold_a: assert property (@(posedge clock) disable iff (!reset_n)
      irq_request[irvm_pkg::VEC_SUPPLY_LEVEL] && !clear_strobe[irvm_pkg::VEC_SUPPLY_LEVEL]
      && !write_take |=> irq_request[irvm_pkg::VEC_SUPPLY_LEVEL])
    else $error("level request dropped without a clear");

  normal_unused_a: assert property (@(posedge clock) disable iff (!reset_n)
      !split_mode && !$past(split_mode) |-> !flag[irvm_pkg::VEC_TIMER_HUNF] || $past(flag[irvm_pkg::VEC_TIMER_HUNF]))
    else $error("vector 9 set in normal mode");

  split_select_a: assert property (@(posedge clock) disable iff (!reset_n)
      split_mode && timer_a_low_underflow_irq |=> flag[irvm_pkg::VEC_TIMER_OVF])
    else $error("split low underflow did not reach vector 8");

  variant_absent_a: assert property (@(posedge clock) disable iff (!reset_n)
      PIN_COUNT < irvm_pkg::PORT_C_MIN_PINS |-> !irq_request[irvm_pkg::VEC_PORT_C])
    else $error("port C request on a small variant");

  priority_pick_a: assert property (@(posedge clock) disable iff (!reset_n)
      request_all[irvm_pkg::VEC_MEM_SCAN_NMI] |=> pending_vector.number == irvm_pkg::VEC_MEM_SCAN_NMI)
    else $error("non-maskable vector lost priority");

  bus_wait_a: assert property (@(posedge clock) disable iff (!reset_n)
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest held beyond one cycle");

  supply_route_a: assert property (@(posedge clock) disable iff (!reset_n)
      supply_level_monitor_irq |=> flag[irvm_pkg::VEC_SUPPLY_LEVEL])
    else $error("supply level event did not reach vector 2");

  port_b_route_a: assert property (@(posedge clock) disable iff (!reset_n)
      port_b_pin_irq && PIN_COUNT >= irvm_pkg::PORT_B_MIN_PINS |=> flag[irvm_pkg::VEC_PORT_B])
    else $error("port B event did not reach vector 4");

  port_c_route_a: assert property (@(posedge clock) disable iff (!reset_n)
      port_c_pin_irq && PIN_COUNT >= irvm_pkg::PORT_C_MIN_PINS |=> flag[irvm_pkg::VEC_PORT_C])
    else $error("port C event did not reach vector 5");

  counter_route_a: assert property (@(posedge clock) disable iff (!reset_n)
      realtime_counter_irq |=> flag[irvm_pkg::VEC_RTC_COUNT])
    else $error("counter event did not reach vector 6");

  tick_route_a: assert property (@(posedge clock) disable iff (!reset_n)
      periodic_tick_irq |=> flag[irvm_pkg::VEC_RTC_TICK])
    else $error("periodic tick did not reach vector 7");

  overflow_route_a: assert property (@(posedge clock) disable iff (!reset_n)
      !split_mode && timer_a_overflow_irq |=> flag[irvm_pkg::VEC_TIMER_OVF])
    else $error("timer overflow did not reach vector 8");

  high_underflow_a: assert property (@(posedge clock) disable iff (!reset_n)
      split_mode && timer_a_high_underflow_irq |=> flag[irvm_pkg::VEC_TIMER_HUNF])
    else $error("high underflow did not reach vector 9");

  compare0_route_a: assert property (@(posedge clock) disable iff (!reset_n)
      !split_mode && timer_a_compare0_irq |=> flag[irvm_pkg::VEC_TIMER_CMP0])
    else $error("compare 0 did not reach vector 10");

  compare1_route_a: assert property (@(posedge clock) disable iff (!reset_n)
      !split_mode && timer_a_compare1_irq |=> flag[irvm_pkg::VEC_TIMER_CMP1])
    else $error("compare 1 did not reach vector 11");

  low_compare2_a: assert property (@(posedge clock) disable iff (!reset_n)
      split_mode && timer_a_low_compare2_irq |=> flag[irvm_pkg::VEC_TIMER_CMP2])
    else $error("low compare 2 did not reach vector 12");

  reset_entry_a: assert property (@(posedge clock) disable iff (!reset_n)
      !irq_request[irvm_pkg::VEC_RESET] && !(pending_vector.valid && pending_vector.number == irvm_pkg::VEC_RESET))
    else $error("reset entry used as an interrupt vector");

  clear_drops_a: assert property (@(posedge clock) disable iff (!reset_n)
      clear_strobe[irvm_pkg::VEC_PORT_A] && !event_vec[irvm_pkg::VEC_PORT_A] |=> !flag[irvm_pkg::VEC_PORT_A])
    else $error("flag survived a clear");

  enable_write_a: assert property (@(posedge clock) disable iff (!reset_n)
      enable_write |=> enable[irvm_pkg::VEC_PORT_A] == $past(bus.writedata[irvm_pkg::VEC_PORT_A]))
    else $error("enable bit did not take the written value");

endmodule : irvm_top

// File: testbench/irvm_cpu_model.sv
// Behavioural CPU side: takes the pending vector and keeps its program entry
`timescale 1ns/1ps
module irvm_cpu_model (
  input wire logic clock,
  input wire logic reset_n,
  input wire irvm_pkg::irvm_vector_type pending_vector,
  output logic [7:0] entry_address,
  output logic taken
);
  // ****************************************
  // Vector fetch
  // ****************************************
  // Reset entry is word zero; a taken vector jumps to its word address
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      entry_address <= 8'h00;
      taken <= 1'b0;
    end else if (pending_vector.valid) begin
      entry_address <= pending_vector.word_address;
      taken <= 1'b1;
    end
  end
endmodule : irvm_cpu_model

// File: testbench/testbench.sv
// Self-checking bench for the interrupt request and vector map
`timescale 1ns/1ps
module testbench;
  localparam int unsigned PINS = 14;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [15:0] src = 16'h0;
  logic [12:0] irq_request;
  logic nonmaskable_request;
  irvm_pkg::irvm_vector_type pending_vector;
  logic global_enable;
  logic split_mode;
  logic [7:0] entry_address;
  logic taken;
  int fail_count = 0;
  int comparisons = 0;
  logic [31:0] d;
  logic [3:0] v;
  logic [31:0] mask;
  logic [3:0] vec_of [16] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8,
                              4'h8, 4'h9, 4'ha, 4'ha, 4'hb, 4'hb, 4'hc, 4'hc};

  always #10 clock = ~clock;

  irvm_top #(.PIN_COUNT(PINS)) dut_u (
    .clock(clock), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .memory_scan_nonmaskable_irq(src[0]),
    .supply_level_monitor_irq(src[1]), .port_a_pin_irq(src[2]), .port_b_pin_irq(src[3]),
    .port_c_pin_irq(src[4]), .realtime_counter_irq(src[5]), .periodic_tick_irq(src[6]),
    .timer_a_overflow_irq(src[7]), .timer_a_low_underflow_irq(src[8]),
    .timer_a_high_underflow_irq(src[9]), .timer_a_compare0_irq(src[10]),
    .timer_a_low_compare0_irq(src[11]), .timer_a_compare1_irq(src[12]),
    .timer_a_low_compare1_irq(src[13]), .timer_a_compare2_irq(src[14]),
    .timer_a_low_compare2_irq(src[15]), .irq_request(irq_request),
    .nonmaskable_request(nonmaskable_request), .pending_vector(pending_vector),
    .global_enable(global_enable), .split_mode(split_mode));

  irvm_cpu_model cpu_u (.clock(clock), .reset_n(reset_n), .pending_vector(pending_vector),
    .entry_address(entry_address), .taken(taken));

  // ****************************************
  // Bus, stimulus and compare tasks
  // ****************************************
  task automatic bus_wait();
    @(posedge clock);
    while (avs_waitrequest !== 1'b0) begin
      @(posedge clock);
    end
  endtask : bus_wait

  task automatic bus_write(input logic [3:0] a, input logic [31:0] wd);
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= 1'b1;
    bus_wait();
    avs_write <= 1'b0;
  endtask : bus_write

  task automatic bus_read(input logic [3:0] a, output logic [31:0] rd);
    @(posedge clock);
    avs_address <= a;
    avs_read <= 1'b1;
    bus_wait();
    rd = avs_readdata;
    avs_read <= 1'b0;
  endtask : bus_read

  task automatic pulse(input logic [15:0] s);
    @(posedge clock);
    src <= s;
    @(posedge clock);
    src <= 16'h0;
  endtask : pulse

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  function automatic logic [31:0] status_of(input logic [12:0] req, input logic [3:0] num);
    return {8'h0, num, 3'h0, (num != 4'h0), 3'h0, req};
  endfunction : status_of

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : summarize

  initial begin
    repeat (40000) @(posedge clock);
    fail_count++;
    $display("ERROR %0t watchdog expired", $time);
    summarize();
  end

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (20) @(posedge clock);
    reset_n <= 1'b1;
    for (int a = 0; a < 5; a++) begin
      bus_read((a == 4) ? 4'h1 : 4'(a * 4), d);
      check(d, irvm_pkg::RESET_READDATA, "reset or unaligned read");
    end
    $display("test reset values done");

    bus_write(irvm_pkg::OFS_ENABLE, 32'h0000_1ffe);
    bus_read(irvm_pkg::OFS_ENABLE, d);
    check(d, 32'h0000_1ffe, "enable readback");
    for (int m = 0; m < 2; m++) begin
      bus_write(irvm_pkg::OFS_CONTROL, {30'h0, m[0], 1'b1});
      @(posedge clock);
      check({30'h0, split_mode, global_enable}, {30'h0, m[0], 1'b1}, "control copy");
      for (int i = 0; i < 16; i++) begin
        v = vec_of[i];
        if (i inside {7, 10, 12, 14} && m == 1) v = 4'h0;
        if (i inside {8, 9, 11, 13, 15} && m == 0) v = 4'h0;
        if (i == 3 && PINS < irvm_pkg::PORT_B_MIN_PINS) v = 4'h0;
        if (i == 4 && PINS < irvm_pkg::PORT_C_MIN_PINS) v = 4'h0;
        mask = (v != 4'h0) ? (32'h1 << v) : 32'h0;
        pulse(16'h1 << i);
        bus_read(irvm_pkg::OFS_FLAGS, d);
        check(d, mask, "flag after event");
        bus_read(irvm_pkg::OFS_STATUS, d);
        check(d, status_of(mask[12:0], v), "status with request");
        check({19'h0, irq_request}, mask, "request port");
        if (v != 4'h0) check({24'h0, entry_address}, {28'h0, v}, "entry address");
        bus_write(irvm_pkg::OFS_FLAGS, mask);
        bus_read(irvm_pkg::OFS_FLAGS, d);
        check(d, 32'h0, "flag after clear");
        check({19'h0, irq_request}, 32'h0, "request after clear");
      end
    end
    check({31'h0, taken}, 32'h1, "vector taken");
    $display("test vector map done");

    bus_write(irvm_pkg::OFS_CONTROL, 32'h0);
    pulse(16'h0005);
    bus_read(irvm_pkg::OFS_STATUS, d);
    check(d, status_of(13'h0002, 4'h1), "global off keeps only nonmaskable");
    check({31'h0, nonmaskable_request}, 32'h1, "nonmaskable port");
    bus_write(irvm_pkg::OFS_CONTROL, 32'h1);
    bus_read(irvm_pkg::OFS_STATUS, d);
    check(d, status_of(13'h000a, 4'h1), "lowest vector wins");
    bus_write(irvm_pkg::OFS_FLAGS, 32'h2);
    bus_read(irvm_pkg::OFS_STATUS, d);
    check(d, status_of(13'h0008, 4'h3), "next vector after clear");
    bus_write(irvm_pkg::OFS_ENABLE, 32'h0);
    bus_read(irvm_pkg::OFS_STATUS, d);
    check(d, status_of(13'h0, 4'h0), "disabled source has no request");
    bus_read(irvm_pkg::OFS_FLAGS, d);
    check(d, 32'h8, "flag stays while disabled");
    $display("test global enable and priority done");
    summarize();
  end
endmodule : testbench
